// [inc/clkgen_regs_pkg.sv]
// constants, types and register layout for the clock generator control registers
package clkgen_regs_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_PLL_OP     = 8'h1C;
   localparam logic [7:0] ADDR_OUT_CTRL   = 8'h1D;
   localparam logic [7:0] ADDR_PIN_FREQ   = 8'h1E;
   localparam logic [7:0] ADDR_PLL2_LOOP  = 8'h1F;
   localparam logic [7:0] ADDR_FREQ_WD    = 8'h20;
   localparam logic [7:0] ADDR_DIFF_PD    = 8'h21;
   localparam int         REG_COUNT       = 6;
   localparam logic [7:0] REG_LAST        = ADDR_DIFF_PD;
   localparam logic [2:0] IDX_FREQ_WD     = 3'h4;
   // reset values and writable masks, index 0 is the first register
   localparam logic [5:0][7:0] REG_RESET = {8'hB0, 8'h80, 8'h84, 8'h90, 8'h33, 8'h3F};
   localparam logic [5:0][7:0] REG_WMASK = {8'h07, 8'h1E, 8'h0E, 8'hE3, 8'hFF, 8'hFF};

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_FINE_SPREAD = 7;
   localparam int BIT_REF_SOURCE  = 6;
   localparam int BIT_DIFF1_GATE  = 7;
   localparam int BIT_DIFF2_GATE  = 6;
   localparam int BIT_DIFF1_ON    = 5;
   localparam int BIT_DIFF2_ON    = 4;
   localparam int BIT_DIV4_SOURCE = 3;
   localparam int BIT_SE1_DRIVE   = 2;
   localparam int VDD1_LSB        = 0;
   localparam int BIT_SINGLE1_ON  = 7;
   localparam int PIN_FUNC_LSB    = 5;
   localparam int SOFT_FREQ_LSB   = 0;
   localparam int BIT_LOOP_ORDER  = 3;
   localparam int BIT_CH2_EN      = 2;
   localparam int BIT_THIRD_POLE  = 1;
   localparam int BIT_FREQ_SW_EN  = 4;
   localparam int BIT_WDOG_ON     = 3;
   localparam int WD_SEL_LSB      = 1;
   localparam int BIT_ALARM       = 0;
   localparam int BIT_PD_TRISTATE = 2;
   localparam int BIT_DIFF1_POL   = 1;
   localparam int BIT_DIFF2_POL   = 0;

   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] FUNC_SE1_OE       = 2'h0;
   localparam logic [1:0] FUNC_POWER_DOWN   = 2'h1;
   localparam logic [1:0] FUNC_POWER_SAVING = 2'h2;
   localparam logic [1:0] FUNC_FREQ_SELECT  = 2'h3;
   localparam logic [2:0] SHIFT_FINE        = 3'h4;
   localparam logic [2:0] SHIFT_NORMAL      = 3'h0;
   // bus address of the device, value is arbitrary
   localparam logic [6:0] DEV_ADDR_DEFAULT  = 7'h5A;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_KHZ          = 250000;
   localparam int WD_PERIOD0_MS    = 250;
   localparam int WD_PERIOD1_MS    = 500;
   localparam int WD_PERIOD2_MS    = 2000;
   localparam int WD_PERIOD3_MS    = 4000;
   localparam int WD_PERIOD0_CYCLES = WD_PERIOD0_MS * CLK_KHZ;
   localparam int WD_PERIOD1_CYCLES = WD_PERIOD1_MS * CLK_KHZ;
   localparam int WD_PERIOD2_CYCLES = WD_PERIOD2_MS * CLK_KHZ;
   localparam int WD_PERIOD3_CYCLES = WD_PERIOD3_MS * CLK_KHZ;
   localparam int WD_WIDTH         = 30;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      LINK_IDLE, LINK_ADDR, LINK_PTR, LINK_WDATA, LINK_RDATA
   } link_state_type;

   typedef struct packed {
      logic [2:0] pll2_step_shift;
      logic       pll2_ref_source;
      logic [5:0] pll_power_lock;
      logic       diff1_enable;
      logic       diff2_enable;
      logic       diff1_tristate;
      logic       diff2_tristate;
      logic       diff1_leg_b_polarity;
      logic       diff2_leg_b_polarity;
      logic       divider4_source;
      logic       single_out1_drive;
      logic       single_out1_enable;
      logic       single_out1_power_saving;
      logic       chip_power_down;
      logic [1:0] freq_index;
      logic       pll2_loop_order;
      logic       pll2_third_pole;
      logic       pll2_channel2_enable;
      logic [1:0] vdd1_level;
      logic       watchdog_alarm;
   } ctrl_out_type;

endpackage

// [logic/clock_gen_control_regs.sv]
// control registers of the clock generator behind a two-wire serial slave
//
// How it works
// [RQ1] fine spread bit shifts step by four
// [RQ2] reference select: crystal or divider two
// [RQ3] gate bit lets second enable gate output1
// [RQ4] gate bit lets second enable gate output2
// [RQ5] enable bits switch differential outputs on
// [RQ6] divider four source: loop two or crystal
// [RQ7] single output drive: normal or strong
// [RQ8] single output enable bit, default on
// [RQ9] two-bit selector assigns multi-function pin role
// [RQ10] soft selector picks frequency set N0-N3
// [RQ11] loop order bit: first or third
// [RQ12] channel two path enable, default on
// [RQ13] watchdog period 250ms to 4s, when enabled
// [RQ14] alarm flag read-only, host cannot write
// [RQ15] power down tri-states outputs when bit set
// [RQ16] flip bit sets second leg polarity
// [RQ17] reserved bits keep and return defaults
`timescale 1ns/1ps
`default_nettype none

module clock_gen_control_regs #(
   parameter int unsigned WD_CYCLES0 = clkgen_regs_pkg::WD_PERIOD0_CYCLES,
   parameter int unsigned WD_CYCLES1 = clkgen_regs_pkg::WD_PERIOD1_CYCLES,
   parameter int unsigned WD_CYCLES2 = clkgen_regs_pkg::WD_PERIOD2_CYCLES,
   parameter int unsigned WD_CYCLES3 = clkgen_regs_pkg::WD_PERIOD3_CYCLES
) (
   input  wire logic                           clk,
   input  wire logic                           reset,
   input  wire logic                           scl_in,
   input  wire logic                           sda_in,
   output var  logic                           sda_out,
   output var  logic                           sda_oe,
   input  wire logic                           multi_pin_in,
   input  wire logic                           oe2_pin_in,
   output var  clkgen_regs_pkg::ctrl_out_type  ctrl
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [3:0] pin_raw;
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] filt_q;
   logic       scl_prev_q;
   logic       sda_prev_q;

   assign pin_raw = {oe2_pin_in, multi_pin_in, sda_in, scl_in};

   // three stages, a change counts once stages two and three agree
   for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk) begin
         if (reset) begin
            s1_q[g]   <= 1'b1;
            s2_q[g]   <= 1'b1;
            s3_q[g]   <= 1'b1;
            filt_q[g] <= 1'b1;
         end else begin
            s1_q[g] <= pin_raw[g];
            s2_q[g] <= s1_q[g];
            s3_q[g] <= s2_q[g];
            if (s2_q[g] == s3_q[g]) begin
               filt_q[g] <= s3_q[g];
            end
         end
      end
   end

   // previous line levels for edge detection
   always_ff @(posedge clk) begin
      if (reset) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= filt_q[0];
         sda_prev_q <= filt_q[1];
      end
   end

   logic scl_f;
   logic sda_f;
   logic multi_pin;
   logic oe2_pin;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // bus events from filtered levels
   assign scl_f     = filt_q[0];
   assign sda_f     = filt_q[1];
   assign multi_pin = filt_q[2];
   assign oe2_pin   = filt_q[3];
   assign scl_rise  = scl_f & ~scl_prev_q;
   assign scl_fall  = ~scl_f & scl_prev_q;
   assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
   assign bus_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

   // ---------------------------------------------------------------
   // serial slave
   // ---------------------------------------------------------------
   clkgen_regs_pkg::link_state_type st_q;
   clkgen_regs_pkg::link_state_type next_st;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] ptr_q;
   logic       ack_q;
   logic       rw_q;
   logic [5:0][7:0] regs_q;
   logic [5:0][7:0] reg_view;
   logic [7:0] rd_byte;
   logic [2:0] idx;
   logic [7:0] ptr_off;
   logic       hit;
   logic       wr_fire;
   logic       load_now;
   logic       alarm_q;

   // address decode, unmapped reads return zero
   assign ptr_off  = ptr_q - clkgen_regs_pkg::ADDR_PLL_OP;
   assign idx      = ptr_off[2:0];
   assign hit      = (ptr_q >= clkgen_regs_pkg::ADDR_PLL_OP) && (ptr_q <= clkgen_regs_pkg::REG_LAST);
   assign rd_byte  = hit ? reg_view[idx] : 8'h00;
   assign next_st  = (st_q == clkgen_regs_pkg::LINK_ADDR) ?
                     (rw_q ? clkgen_regs_pkg::LINK_RDATA : clkgen_regs_pkg::LINK_PTR) :
                     clkgen_regs_pkg::LINK_WDATA;
   assign wr_fire  = scl_fall & (st_q == clkgen_regs_pkg::LINK_WDATA) & (cnt_q == 4'h8) & ~ack_q;
   assign load_now = scl_fall & (((st_q == clkgen_regs_pkg::LINK_RDATA) & (cnt_q == 4'h9)) |
                     ((st_q == clkgen_regs_pkg::LINK_ADDR) & ack_q & rw_q & (cnt_q == 4'h8)));

   // byte engine: shift on rising clock, drive and ack on falling clock
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q  <= clkgen_regs_pkg::LINK_IDLE;
         cnt_q <= 4'h0;
         sh_q  <= 8'h00;
         ptr_q <= 8'h00;
         ack_q <= 1'b0;
         rw_q  <= 1'b0;
         sda_oe <= 1'b0;
      end else if (bus_start) begin
         st_q   <= clkgen_regs_pkg::LINK_ADDR;
         cnt_q  <= 4'h0;
         ack_q  <= 1'b0;
         sda_oe <= 1'b0;
      end else if (bus_stop) begin
         st_q   <= clkgen_regs_pkg::LINK_IDLE;
         ack_q  <= 1'b0;
         sda_oe <= 1'b0;
      end else if (load_now) begin
         st_q   <= clkgen_regs_pkg::LINK_RDATA;
         ack_q  <= 1'b0;
         sda_oe <= ~rd_byte[7];
         sh_q   <= {rd_byte[6:0], 1'b1};
         cnt_q  <= 4'h1;
         ptr_q  <= ptr_q + 8'h01;
      end else if (scl_rise) begin
         if (st_q == clkgen_regs_pkg::LINK_RDATA) begin
            if (cnt_q == 4'h9 && sda_f) begin
               st_q <= clkgen_regs_pkg::LINK_IDLE; // master ends the read
            end
         end else if (st_q != clkgen_regs_pkg::LINK_IDLE && cnt_q < 4'h8) begin
            sh_q  <= {sh_q[6:0], sda_f};
            cnt_q <= cnt_q + 4'h1;
         end
      end else if (scl_fall && st_q == clkgen_regs_pkg::LINK_RDATA) begin
         if (cnt_q == 4'h8) begin
            sda_oe <= 1'b0;
            cnt_q  <= 4'h9;
         end else begin
            sda_oe <= ~sh_q[7];
            sh_q   <= {sh_q[6:0], 1'b1};
            cnt_q  <= cnt_q + 4'h1;
         end
      end else if (scl_fall && st_q != clkgen_regs_pkg::LINK_IDLE && cnt_q == 4'h8) begin
         if (ack_q) begin
            ack_q  <= 1'b0;
            sda_oe <= 1'b0;
            cnt_q  <= 4'h0;
            st_q   <= next_st;
         end else if (st_q == clkgen_regs_pkg::LINK_ADDR) begin
            if (sh_q[7:1] == clkgen_regs_pkg::DEV_ADDR_DEFAULT) begin
               ack_q  <= 1'b1;
               sda_oe <= 1'b1;
               rw_q   <= sh_q[0];
            end else begin
               st_q <= clkgen_regs_pkg::LINK_IDLE;
            end
         end else begin
            ack_q  <= 1'b1;
            sda_oe <= 1'b1;
            ptr_q  <= (st_q == clkgen_regs_pkg::LINK_PTR) ? sh_q : ptr_q + 8'h01;
         end
      end
   end

   // open-drain data line only ever pulls low
   always_ff @(posedge clk) begin
      sda_out <= 1'b0;
   end

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   // reserved and read-only bits hold their reset value on writes
   for (genvar r = 0; r < clkgen_regs_pkg::REG_COUNT; r++) begin : g_reg
      always_ff @(posedge clk) begin
         if (reset) begin
            regs_q[r] <= clkgen_regs_pkg::REG_RESET[r];
         end else if (wr_fire && hit && idx == 3'(r)) begin
            regs_q[r] <= (sh_q & clkgen_regs_pkg::REG_WMASK[r]) |
                         (clkgen_regs_pkg::REG_RESET[r] & ~clkgen_regs_pkg::REG_WMASK[r]); // [RQ17]
         end
      end
   end

   // read view with the live alarm flag inserted
   always_comb begin
      reg_view = regs_q;
      reg_view[clkgen_regs_pkg::IDX_FREQ_WD][clkgen_regs_pkg::BIT_ALARM] = alarm_q; // [RQ14]
   end

   // named fields
   logic       pll2_fine_spread_en;
   logic       pll2_ref_source;
   logic       diff1_second_enable_gate;
   logic       diff2_second_enable_gate;
   logic       diff1_out_enable;
   logic       diff2_out_enable;
   logic       divider4_source;
   logic       single_out1_drive;
   logic       single_out1_enable;
   logic [1:0] multi_pin_function;
   logic [1:0] soft_freq_select;
   logic       freq_switch_enable;
   logic       pll2_loop_order;
   logic       pll2_channel2_enable;
   logic       watchdog_enable;
   logic [1:0] wd_select;
   logic       diff_pd_tristate;
   logic       diff1_leg_b_polarity;
   logic       diff2_leg_b_polarity;

   assign pll2_fine_spread_en      = regs_q[0][clkgen_regs_pkg::BIT_FINE_SPREAD];
   assign pll2_ref_source          = regs_q[0][clkgen_regs_pkg::BIT_REF_SOURCE];
   assign diff1_second_enable_gate = regs_q[1][clkgen_regs_pkg::BIT_DIFF1_GATE];
   assign diff2_second_enable_gate = regs_q[1][clkgen_regs_pkg::BIT_DIFF2_GATE];
   assign diff1_out_enable         = regs_q[1][clkgen_regs_pkg::BIT_DIFF1_ON];
   assign diff2_out_enable         = regs_q[1][clkgen_regs_pkg::BIT_DIFF2_ON];
   assign divider4_source          = regs_q[1][clkgen_regs_pkg::BIT_DIV4_SOURCE];
   assign single_out1_drive        = regs_q[1][clkgen_regs_pkg::BIT_SE1_DRIVE];
   assign single_out1_enable       = regs_q[2][clkgen_regs_pkg::BIT_SINGLE1_ON];
   assign multi_pin_function       = regs_q[2][clkgen_regs_pkg::PIN_FUNC_LSB +: 2];
   assign soft_freq_select         = regs_q[2][clkgen_regs_pkg::SOFT_FREQ_LSB +: 2];
   assign pll2_loop_order          = regs_q[3][clkgen_regs_pkg::BIT_LOOP_ORDER];
   assign pll2_channel2_enable     = regs_q[3][clkgen_regs_pkg::BIT_CH2_EN];
   assign freq_switch_enable       = regs_q[4][clkgen_regs_pkg::BIT_FREQ_SW_EN];
   assign watchdog_enable          = regs_q[4][clkgen_regs_pkg::BIT_WDOG_ON];
   assign wd_select                = regs_q[4][clkgen_regs_pkg::WD_SEL_LSB +: 2];
   assign diff_pd_tristate         = regs_q[5][clkgen_regs_pkg::BIT_PD_TRISTATE];
   assign diff1_leg_b_polarity     = regs_q[5][clkgen_regs_pkg::BIT_DIFF1_POL];
   assign diff2_leg_b_polarity     = regs_q[5][clkgen_regs_pkg::BIT_DIFF2_POL];

   // ---------------------------------------------------------------
   // watchdog
   // ---------------------------------------------------------------
   logic [clkgen_regs_pkg::WD_WIDTH-1:0] wd_cnt_q;
   logic [clkgen_regs_pkg::WD_WIDTH-1:0] wd_limit;
   logic                                 wd_hit;

   // period per selector code, a register write restarts the count
   assign wd_limit = (wd_select == 2'h0) ? 30'(WD_CYCLES0 - 1) :
                     (wd_select == 2'h1) ? 30'(WD_CYCLES1 - 1) :
                     (wd_select == 2'h2) ? 30'(WD_CYCLES2 - 1) : 30'(WD_CYCLES3 - 1); // [RQ13]
   assign wd_hit   = watchdog_enable & (wd_cnt_q >= wd_limit);

   always_ff @(posedge clk) begin
      if (reset || !watchdog_enable || wr_fire || wd_hit) begin
         wd_cnt_q <= '0; // [RQ13]
      end else begin
         wd_cnt_q <= wd_cnt_q + 30'h1;
      end
   end

   // sticky alarm, set wins over the clear by disabling
   always_ff @(posedge clk) begin
      if (reset) begin
         alarm_q <= 1'b0;
      end else begin
         alarm_q <= wd_hit | (alarm_q & watchdog_enable); // [RQ14]
      end
   end

   // ---------------------------------------------------------------
   // derived controls
   // ---------------------------------------------------------------
   logic                          pin_pd;
   logic                          pin_se1_off;
   clkgen_regs_pkg::ctrl_out_type ctrl_d;

   // multi-function pin roles, low level is the active one
   assign pin_pd      = (multi_pin_function == clkgen_regs_pkg::FUNC_POWER_DOWN) & ~multi_pin; // [RQ9]
   assign pin_se1_off = (multi_pin_function == clkgen_regs_pkg::FUNC_SE1_OE) & ~multi_pin; // [RQ9]

   always_comb begin
      ctrl_d = '0;
      ctrl_d.pll2_step_shift = pll2_fine_spread_en ? clkgen_regs_pkg::SHIFT_FINE :
                               clkgen_regs_pkg::SHIFT_NORMAL; // [RQ1]
      ctrl_d.pll2_ref_source = pll2_ref_source; // [RQ2]
      ctrl_d.pll_power_lock  = regs_q[0][5:0];
      ctrl_d.diff1_enable    = diff1_out_enable & (~diff1_second_enable_gate | oe2_pin)
                               & ~pin_pd; // [RQ3] [RQ5]
      ctrl_d.diff2_enable    = diff2_out_enable & (~diff2_second_enable_gate | oe2_pin)
                               & ~pin_pd; // [RQ4] [RQ5]
      ctrl_d.diff1_tristate  = pin_pd & diff_pd_tristate; // [RQ15]
      ctrl_d.diff2_tristate  = pin_pd & diff_pd_tristate; // [RQ15]
      ctrl_d.diff1_leg_b_polarity = diff1_leg_b_polarity; // [RQ16]
      ctrl_d.diff2_leg_b_polarity = diff2_leg_b_polarity; // [RQ16]
      ctrl_d.divider4_source      = divider4_source; // [RQ6]
      ctrl_d.single_out1_drive    = single_out1_drive; // [RQ7]
      ctrl_d.single_out1_enable   = single_out1_enable & ~pin_se1_off & ~pin_pd; // [RQ8]
      ctrl_d.single_out1_power_saving =
         (multi_pin_function == clkgen_regs_pkg::FUNC_POWER_SAVING) & ~multi_pin; // [RQ9]
      ctrl_d.chip_power_down = pin_pd;
      ctrl_d.freq_index = (freq_switch_enable &&
                           multi_pin_function == clkgen_regs_pkg::FUNC_FREQ_SELECT) ?
                          {soft_freq_select[1], multi_pin} : soft_freq_select; // [RQ10]
      ctrl_d.pll2_loop_order      = pll2_loop_order; // [RQ11]
      ctrl_d.pll2_third_pole      = regs_q[3][clkgen_regs_pkg::BIT_THIRD_POLE];
      ctrl_d.pll2_channel2_enable = pll2_channel2_enable; // [RQ12]
      ctrl_d.vdd1_level           = regs_q[1][clkgen_regs_pkg::VDD1_LSB +: 2];
      ctrl_d.watchdog_alarm       = alarm_q;
   end

   // registered control outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= '0;
      end else begin
         ctrl <= ctrl_d;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_fine_shift;
      @(posedge clk) disable iff (reset)
      pll2_fine_spread_en |=> ctrl.pll2_step_shift == clkgen_regs_pkg::SHIFT_FINE;
   endproperty
   a_fine_shift: assert property (p_fine_shift) else $error("fine spread shift wrong"); // [RQ1]

   property p_ref_source;
      @(posedge clk) disable iff (reset)
      ##1 ctrl.pll2_ref_source == $past(pll2_ref_source);
   endproperty
   a_ref_source: assert property (p_ref_source) else $error("reference source wrong"); // [RQ2]

   property p_diff1_gate;
      @(posedge clk) disable iff (reset)
      diff1_second_enable_gate && !oe2_pin |=> !ctrl.diff1_enable;
   endproperty
   a_diff1_gate: assert property (p_diff1_gate) else $error("output1 not gated"); // [RQ3]

   property p_diff2_ungated;
      @(posedge clk) disable iff (reset)
      !diff2_second_enable_gate && diff2_out_enable && !pin_pd |=> ctrl.diff2_enable;
   endproperty
   a_diff2_ungated: assert property (p_diff2_ungated) else $error("output2 wrongly off"); // [RQ4]

   property p_diff_enable;
      @(posedge clk) disable iff (reset)
      !diff1_out_enable |=> !ctrl.diff1_enable;
   endproperty
   a_diff_enable: assert property (p_diff_enable) else $error("output1 enable ignored"); // [RQ5]

   property p_se1_enable;
      @(posedge clk) disable iff (reset)
      !single_out1_enable |=> !ctrl.single_out1_enable;
   endproperty
   a_se1_enable: assert property (p_se1_enable) else $error("single output enable"); // [RQ8]

   property p_wd_bound;
      @(posedge clk) disable iff (reset)
      wd_cnt_q <= wd_limit || !watchdog_enable;
   endproperty
   a_wd_bound: assert property (p_wd_bound) else $error("watchdog overran period"); // [RQ13]

   property p_alarm_cause;
      @(posedge clk) disable iff (reset)
      $rose(alarm_q) |-> $past(watchdog_enable) && $past(wd_cnt_q) >= $past(wd_limit);
   endproperty
   a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without timeout"); // [RQ14]

   property p_pd_tristate;
      @(posedge clk) disable iff (reset)
      pin_pd && diff_pd_tristate |=> ctrl.diff1_tristate && ctrl.diff2_tristate;
   endproperty
   a_pd_tristate: assert property (p_pd_tristate) else $error("no tri-state in power down"); // [RQ15]

   property p_reserved;
      @(posedge clk) disable iff (reset)
      wr_fire && hit |=> ((regs_q[$past(idx)] ^ clkgen_regs_pkg::REG_RESET[$past(idx)])
                          & ~clkgen_regs_pkg::REG_WMASK[$past(idx)]) == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit changed"); // [RQ17]

   c_write: cover property (@(posedge clk) disable iff (reset) wr_fire && hit);
   c_read:  cover property (@(posedge clk) disable iff (reset) load_now);
   c_alarm: cover property (@(posedge clk) disable iff (reset) $rose(alarm_q));
   c_pd:    cover property (@(posedge clk) disable iff (reset) ctrl.diff1_tristate);

endmodule

`default_nettype wire

// [sim/i2c_host_model.sv]
// two-wire bus host model that drives the register block
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
   input  wire logic clk,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_low
);
   // bus idle: clock high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // wait a number of falling clock edges
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one bit: 8 cycles low, 8 high, sampled just before the fall
   task automatic bit_io(input logic b, output logic r);
      sda_low = ~b;
      tick(4);
      scl = 1'b1;
      tick(8);
      r = sda_line;
      scl = 1'b0;
      tick(4);
   endtask
   // start, also used as repeated start
   task automatic start();
      sda_low = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(8);
      sda_low = 1'b1;
      tick(8);
      scl = 1'b0;
      tick(4);
   endtask
   // stop: data rises while clock high
   task automatic stop();
      sda_low = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(8);
      sda_low = 1'b0;
      tick(8);
   endtask
   // eight bits msb first, then the ninth (ack) bit
   task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r,
                       output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(a, ack);
   endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// testbench for the clock generator control registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, reset = 1'b1, multi_pin_in = 1'b1, oe2_pin_in = 1'b1;
   logic sda_out, sda_oe, scl, sda_low;
   clkgen_regs_pkg::ctrl_out_type ctrl;
   wire logic sda_line = ~(sda_low | (sda_oe & ~sda_out));
   int err_count = 0, tests_run = 0;
   logic [7:0] pats [4] = '{8'hA5, 8'h52, 8'h71, 8'h90};
   int per [4] = '{200, 400, 800, 1600};
   // 250 MHz clock
   always #2 clk = ~clk;
   clock_gen_control_regs #(.WD_CYCLES0(200), .WD_CYCLES1(400), .WD_CYCLES2(800),
      .WD_CYCLES3(1600)) i_dut (.clk(clk), .reset(reset), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .multi_pin_in(multi_pin_in), .oe2_pin_in(oe2_pin_in), .ctrl(ctrl));
   i2c_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
   // compare one byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // send a byte and expect the device to acknowledge it
   task automatic sendb(input logic [7:0] b);
      logic [7:0] r;
      logic k;
      i_host.xfer(b, 1'b1, r, k);
      chk({7'h0, k}, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.start();
      sendb({clkgen_regs_pkg::DEV_ADDR_DEFAULT, 1'b0});
      sendb(a);
      sendb(d);
      i_host.stop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic k;
      i_host.start();
      sendb({clkgen_regs_pkg::DEV_ADDR_DEFAULT, 1'b0});
      sendb(a);
      i_host.start();
      sendb({clkgen_regs_pkg::DEV_ADDR_DEFAULT, 1'b1});
      i_host.xfer(8'hFF, 1'b1, d, k);
      i_host.stop();
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      print_verdict();
   end
   // main sequence
   initial begin
      logic [7:0] p, v, d;
      logic [1:0] f;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 7; i++) begin
         rd(8'h1C + i[7:0], d);
         chk(d, i < 6 ? clkgen_regs_pkg::REG_RESET[i] : 8'h00);
      end
      foreach (pats[j]) begin
         p = pats[j];
         for (int i = 0; i < 6; i++) begin
            v = (p & clkgen_regs_pkg::REG_WMASK[i]) | (clkgen_regs_pkg::REG_RESET[i]
               & ~clkgen_regs_pkg::REG_WMASK[i]);
            wr(8'h1C + i[7:0], v | (i == 4 ? 8'h01 : 8'h00));
            rd(8'h1C + i[7:0], d);
            chk(d, v);
         end
         chk({ctrl.pll2_step_shift, ctrl.pll2_ref_source, ctrl.diff1_enable, ctrl.diff2_enable,
            ctrl.divider4_source, ctrl.single_out1_drive},
            {p[7] ? 3'h4 : 3'h0, p[6:2]});
         chk({ctrl.single_out1_enable, ctrl.freq_index, ctrl.pll2_loop_order,
            ctrl.pll2_channel2_enable, ctrl.diff1_leg_b_polarity, ctrl.diff2_leg_b_polarity,
            1'b0}, {p[7], p[1:0], p[3:0], 1'b0});
         chk({ctrl.pll_power_lock, ctrl.vdd1_level}, {p[5:0], p[1:0]});
         oe2_pin_in = 1'b0;
         repeat (10) @(negedge clk);
         chk({6'h0, ctrl.diff1_enable, ctrl.diff2_enable},
            {6'h0, p[5] & ~p[7], p[4] & ~p[6]});
         oe2_pin_in = 1'b1;
         multi_pin_in = 1'b0;
         repeat (10) @(negedge clk);
         f = p[6:5];
         chk({ctrl.single_out1_enable, ctrl.chip_power_down, ctrl.single_out1_power_saving,
            ctrl.diff1_tristate, ctrl.freq_index, ctrl.diff1_enable, 1'b0},
            {p[7] & (f > 2'h1), f == 2'h1, f == 2'h2, f == 2'h1 && p[2],
            (f == 2'h3 && p[4]) ? {p[1], 1'b0} : p[1:0], p[5] & (f != 2'h1),
            1'b0});
         chk({6'h0, ctrl.diff2_tristate, ctrl.pll2_third_pole},
            {6'h0, f == 2'h1 && p[2], p[1]});
         multi_pin_in = 1'b1;
      end
      for (int s = 0; s < 4; s++) begin
         wr(clkgen_regs_pkg::ADDR_FREQ_WD, 8'h88 | {s[1:0], 1'b0});
         repeat (per[s] / 2) @(negedge clk);
         chk({7'h0, ctrl.watchdog_alarm}, 8'h00);
         repeat (per[s] / 2 + 20) @(negedge clk);
         chk({7'h0, ctrl.watchdog_alarm}, 8'h01);
         wr(clkgen_regs_pkg::ADDR_FREQ_WD, 8'h88 | {s[1:0], 1'b0});
         rd(clkgen_regs_pkg::ADDR_FREQ_WD, d);
         chk(d, 8'h89 | {s[1:0], 1'b0});
         wr(clkgen_regs_pkg::ADDR_FREQ_WD, 8'h81);
         rd(clkgen_regs_pkg::ADDR_FREQ_WD, d);
         chk(d, 8'h80);
      end
      repeat (2000) @(negedge clk);
      chk({7'h0, ctrl.watchdog_alarm}, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
